// file: common/debug_engine_consts.vh
// Constants of the debug command engine: op codes, command codes,
// status codes, register indices, control bit positions and counts.
// Assumes it is included by its bare name from core/ design files.
`ifndef DEBUG_ENGINE_CONSTS_VH
`define DEBUG_ENGINE_CONSTS_VH

// ---------------------------------------------------------------
// Host op codes
// ---------------------------------------------------------------
`define OP_READ_MAP      8'h21
`define OP_WRITE_MEM     8'h25
`define OP_TRACE         8'h26
`define OP_RETURN        8'h27
`define OP_UNLOCK        8'h28
`define OP_READ_REG      8'h29

// ---------------------------------------------------------------
// Command code field values and ROM entry address
// ---------------------------------------------------------------
`define CMD_NONE         4'h0
`define CMD_READ_MAP     4'h1
`define CMD_WRITE_MEM    4'h5
`define CMD_UNLOCK       4'h8
`define CMD_READ_REG     4'h9
`define ROM_ENTRY        16'h8010

// ---------------------------------------------------------------
// Link status codes
// ---------------------------------------------------------------
`define ST_NON_DEBUG     2'h0
`define ST_IDLE          2'h1
`define ST_BUSY          2'h2
`define ST_VALID         2'h3

// ---------------------------------------------------------------
// Register indices
// ---------------------------------------------------------------
`define REG_CONTROL      3'h0
`define REG_ADDR_HOLD    3'h1
`define REG_DATA_HOLD    3'h2
`define REG_BYTE_BUF     3'h3
`define REG_WORD_OUT     3'h4
`define REG_STACK_RPT    3'h5
`define REG_MAP_COUNT    3'h6

// ---------------------------------------------------------------
// Control register bits, word port flags
// ---------------------------------------------------------------
`define CTL_XFER_DONE    4
`define CTL_PW_LOCK      5
`define CTL_BYTE_READY   6
`define CTL_SERVICE_END  7
`define WORD_NARROW      16
`define WORD_BLANK       17

// ---------------------------------------------------------------
// Counts and reset values
// ---------------------------------------------------------------
`define WRITE_MEM_BYTES  3'h4
`define READ_REG_BYTES   3'h2
`define UNLOCK_BYTES     32
`define MAP_WORDS        216
`define PERIPH_WORDS     180
`define MAP_HEADER_BYTE  8'hb4
`define PW_LOCK_RESET    1'b1

`endif

// file: core/debug_command_engine.v
// Debug command engine: decodes host debug commands, fills the
// holding registers, vectors the CPU to the ROM service routine and
// streams result bytes back through the byte buffer.
// Assumes host bytes and transfer-end pulses are synchronous to
// sys_clk and that the ROM service code drives the register port.
//
// What this block does
// - Write-memory op code takes four bytes: address low/high, data low/high
// - Write-memory address and data land in the holders, readable by ROM
// - After write-memory bytes, command field 0101b and jump to 8010h
// - Trace leaves debug mode for one CPU step, then re-enters it
// - Return leaves debug mode; CPU resumes where it was stopped
// - Unlock takes 32 bytes; ROM match clears the password lock bit
// - Unlock op code sets command field 1000b and jumps to ROM entry
// - Each unlock byte goes into the byte buffer as it arrives
// - Read-register takes two address bytes, low first, into address holder
// - After read-register bytes, command field 1001b and jump to ROM
// - Single register read always returns 16 bits, low byte first
// - Register reads show pre-entry values; stack pointer shown plus one
// - Map readout sends one byte of the buffer per host transfer
// - Host starts each transfer; valid bytes carry status 11b
// - Transfer end clears the done flag unless an upper byte is pending; loading the buffer sets it
// - Idle status is shown once the whole map has been sent
// - Map covers peripheral words first, then the system registers
// - Peripheral words go as 16 bits, low first, narrow ones with their upper byte as written
// - System registers go at native 8 or 16 bit width
// - Data buffer registers are reported as 0000h, never read
// - First map byte is B4h; the readout holds 216 words
// - Undefined op codes are ignored as no-operations
// - Busy status 10b is reported while a command is processed
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "debug_engine_consts.vh"

module debug_command_engine #(
   parameter MAP_WORDS    = `MAP_WORDS,
   parameter PERIPH_WORDS = `PERIPH_WORDS,
   parameter UNLOCK_BYTES = `UNLOCK_BYTES
) (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        srst,

   // Host link
   input  wire [7:0]  hostByte,
   input  wire        hostByteValid,
   input  wire        hostXferEnd,
   output wire [1:0]  linkStatus,
   output wire [7:0]  linkByte,

   // CPU side
   input  wire        debugEntry,
   input  wire [15:0] stackPtr,
   input  wire        stepDone,
   output wire        inDebug,
   output wire        vectorReq,
   output wire [15:0] vectorAddr,
   output wire        stepReq,
   output wire        resumeReq,

   // Register port
   input  wire [2:0]  regAddr,
   input  wire [31:0] regWrData,
   input  wire        regWr,
   input  wire        regRd,
   output wire [31:0] regRdData
);

   // ---------------------------------------------------------------
   // Sequencer states
   // ---------------------------------------------------------------
   localparam [2:0] S_OFF     = 3'h0;
   localparam [2:0] S_IDLE    = 3'h1;
   localparam [2:0] S_COLLECT = 3'h2;
   localparam [2:0] S_SERVICE = 3'h3;
   localparam [2:0] S_UNLOCK  = 3'h4;
   localparam [2:0] S_READOUT = 3'h5;
   localparam [2:0] S_TRACE   = 3'h6;

   // Counts worked out at full width, then cut to the counter widths
   localparam [31:0] LAST_WORD_W   = MAP_WORDS - 1;
   localparam [31:0] PERIPH_LAST_W = PERIPH_WORDS - 1;
   localparam [31:0] LAST_UNLOCK_W = UNLOCK_BYTES - 1;
   localparam [7:0]  LAST_WORD     = LAST_WORD_W[7:0];
   localparam [7:0]  PERIPH_LAST   = PERIPH_LAST_W[7:0];
   localparam [5:0]  LAST_UNLOCK   = LAST_UNLOCK_W[5:0];

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   reg [2:0]  state_ff;
   reg        debugMode_ff;
   reg [3:0]  cmdCode_ff;
   reg [3:0]  pendCmd_ff;
   reg [2:0]  needBytes_ff;
   reg [5:0]  byteIdx_ff;

   reg [15:0] addrHold_ff;
   reg [15:0] dataHold_ff;

   reg [7:0]  byteBuf_ff;
   reg [7:0]  highByte_ff;
   reg        highPend_ff;
   reg        xferDone_ff;
   reg        pwLock_ff;
   reg        byteReady_ff;
   reg        headerPend_ff;

   reg [7:0]  wordCnt_ff;
   reg [15:0] stackRpt_ff;
   reg [1:0]  status_ff;
   reg        vectorReq_ff;
   reg [15:0] vectorAddr_ff;
   reg        stepReq_ff;
   reg        resumeReq_ff;

   reg [31:0] rdData_ff;
   reg [1:0]  nxt_status;
   reg [31:0] nxt_rdData;

   // ---------------------------------------------------------------
   // Decoded register strobes
   // ---------------------------------------------------------------
   wire wrCtrl  = regWr && (regAddr == `REG_CONTROL);
   wire wrAddr  = regWr && (regAddr == `REG_ADDR_HOLD);
   wire wrData  = regWr && (regAddr == `REG_DATA_HOLD);
   wire wrByte  = regWr && (regAddr == `REG_BYTE_BUF);
   wire wrWord  = regWr && (regAddr == `REG_WORD_OUT);
   wire svcEnd  = wrCtrl && regWrData[`CTL_SERVICE_END];
   // A transfer end only counts while a byte is actually on offer
   wire xferEnd = hostXferEnd && xferDone_ff;
   // Map words below the peripheral count are always sent wide
   wire inPeriph = (state_ff == S_READOUT) && (wordCnt_ff <= PERIPH_LAST);
   wire wordWide = inPeriph || (state_ff != S_READOUT) ||
                   !regWrData[`WORD_NARROW];
   wire [15:0] wordVal = regWrData[`WORD_BLANK] ? 16'h0000 :
                         regWrData[15:0];
   wire wordClosed = xferEnd && !highPend_ff && !headerPend_ff;

   // ---------------------------------------------------------------
   // Link status
   // ---------------------------------------------------------------
   always @* begin
      // A trace step counts as a command in progress, so it shows busy
      if (!debugMode_ff && (state_ff != S_TRACE))
         nxt_status = `ST_NON_DEBUG;
      else if (xferDone_ff)
         nxt_status = `ST_VALID;
      else if (state_ff != S_IDLE)
         nxt_status = `ST_BUSY;
      else
         nxt_status = `ST_IDLE;
   end

   // ---------------------------------------------------------------
   // Register read mux
   // ---------------------------------------------------------------
   always @* begin
      nxt_rdData = 32'h00000000;
      case (regAddr)
         `REG_CONTROL: begin
            nxt_rdData[3:0]             = cmdCode_ff;
            nxt_rdData[`CTL_XFER_DONE]  = xferDone_ff;
            nxt_rdData[`CTL_PW_LOCK]    = pwLock_ff;
            nxt_rdData[`CTL_BYTE_READY] = byteReady_ff;
         end
         `REG_ADDR_HOLD: nxt_rdData[15:0] = addrHold_ff;
         `REG_DATA_HOLD: nxt_rdData[15:0] = dataHold_ff;
         `REG_BYTE_BUF:  nxt_rdData[7:0]  = byteBuf_ff;
         `REG_STACK_RPT: nxt_rdData[15:0] = stackRpt_ff;
         `REG_MAP_COUNT: nxt_rdData[7:0]  = wordCnt_ff;
         default:        nxt_rdData = 32'h00000000;
      endcase
   end

   always @(posedge sys_clk) begin
      if (srst)
         rdData_ff <= 32'h00000000;
      else if (regRd)
         rdData_ff <= nxt_rdData;
      else
         rdData_ff <= 32'h00000000;
   end

   // ---------------------------------------------------------------
   // Sequencer and registers
   // ---------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (srst) begin
         state_ff      <= S_OFF;
         debugMode_ff  <= 1'b0;
         cmdCode_ff    <= `CMD_NONE;
         pendCmd_ff    <= `CMD_NONE;
         needBytes_ff  <= 3'h0;
         byteIdx_ff    <= 6'h00;
         addrHold_ff   <= 16'h0000;
         dataHold_ff   <= 16'h0000;
         byteBuf_ff    <= 8'h00;
         highByte_ff   <= 8'h00;
         highPend_ff   <= 1'b0;
         xferDone_ff   <= 1'b0;
         pwLock_ff     <= `PW_LOCK_RESET;
         byteReady_ff  <= 1'b0;
         headerPend_ff <= 1'b0;
         wordCnt_ff    <= 8'h00;
         stackRpt_ff   <= 16'h0000;
         status_ff     <= `ST_NON_DEBUG;
         vectorReq_ff  <= 1'b0;
         vectorAddr_ff <= `ROM_ENTRY;
         stepReq_ff    <= 1'b0;
         resumeReq_ff  <= 1'b0;
      end else begin
         status_ff    <= nxt_status;
         vectorReq_ff <= 1'b0;
         stepReq_ff   <= 1'b0;
         resumeReq_ff <= 1'b0;

         // Software side of the control register; a clear here is
         // placed before any hardware set so that the set wins.
         if (wrCtrl && !regWrData[`CTL_PW_LOCK])
            pwLock_ff <= 1'b0;
         if (wrCtrl && regWrData[`CTL_BYTE_READY])
            byteReady_ff <= 1'b0;
         if (wrAddr)
            addrHold_ff <= regWrData[15:0];
         if (wrData)
            dataHold_ff <= regWrData[15:0];

         // End of a host transfer: hand over the upper byte or free
         // the buffer for the ROM.
         if (xferEnd) begin
            headerPend_ff <= 1'b0;
            if (highPend_ff) begin
               byteBuf_ff  <= highByte_ff;
               highPend_ff <= 1'b0;
            end else
               xferDone_ff <= 1'b0;
         end

         // ROM loads; placed after the clear so a load wins
         if (wrByte) begin
            byteBuf_ff  <= regWrData[7:0];
            xferDone_ff <= 1'b1;
         end
         if (wrWord) begin
            byteBuf_ff  <= wordVal[7:0];
            highByte_ff <= wordVal[15:8];
            highPend_ff <= wordWide;
            xferDone_ff <= 1'b1;
         end

         case (state_ff)
            S_OFF: begin
               if (debugEntry) begin
                  debugMode_ff <= 1'b1;
                  stackRpt_ff  <= stackPtr + 16'h0001;
                  state_ff     <= S_IDLE;
               end
            end

            S_IDLE: begin
               if (hostByteValid) begin
                  byteIdx_ff <= 6'h00;
                  case (hostByte)
                     `OP_WRITE_MEM: begin
                        pendCmd_ff   <= `CMD_WRITE_MEM;
                        needBytes_ff <= `WRITE_MEM_BYTES;
                        state_ff     <= S_COLLECT;
                     end
                     `OP_READ_REG: begin
                        pendCmd_ff   <= `CMD_READ_REG;
                        needBytes_ff <= `READ_REG_BYTES;
                        state_ff     <= S_COLLECT;
                     end
                     `OP_UNLOCK: begin
                        cmdCode_ff    <= `CMD_UNLOCK;
                        vectorReq_ff  <= 1'b1;
                        vectorAddr_ff <= `ROM_ENTRY;
                        state_ff      <= S_UNLOCK;
                     end
                     `OP_TRACE: begin
                        debugMode_ff <= 1'b0;
                        stepReq_ff   <= 1'b1;
                        state_ff     <= S_TRACE;
                     end
                     `OP_RETURN: begin
                        debugMode_ff <= 1'b0;
                        resumeReq_ff <= 1'b1;
                        state_ff     <= S_OFF;
                     end
                     `OP_READ_MAP: begin
                        cmdCode_ff    <= `CMD_READ_MAP;
                        vectorReq_ff  <= 1'b1;
                        vectorAddr_ff <= `ROM_ENTRY;
                        byteBuf_ff    <= `MAP_HEADER_BYTE;
                        xferDone_ff   <= 1'b1;
                        headerPend_ff <= 1'b1;
                        highPend_ff   <= 1'b0;
                        wordCnt_ff    <= 8'h00;
                        state_ff      <= S_READOUT;
                     end
                     default: state_ff <= S_IDLE;
                  endcase
               end
            end

            S_COLLECT: begin
               if (hostByteValid) begin
                  // Bytes come address low, address high, data low,
                  // data high.
                  case (byteIdx_ff[1:0])
                     2'h0: addrHold_ff[7:0]  <= hostByte;
                     2'h1: addrHold_ff[15:8] <= hostByte;
                     2'h2: dataHold_ff[7:0]  <= hostByte;
                     default: dataHold_ff[15:8] <= hostByte;
                  endcase
                  byteIdx_ff <= byteIdx_ff + 6'h01;
                  if (byteIdx_ff[2:0] == needBytes_ff - 3'h1) begin
                     cmdCode_ff    <= pendCmd_ff;
                     vectorReq_ff  <= 1'b1;
                     vectorAddr_ff <= `ROM_ENTRY;
                     state_ff      <= S_SERVICE;
                  end
               end
            end

            S_UNLOCK: begin
               // The ROM compares the password; only the bytes pass here
               if (hostByteValid) begin
                  byteBuf_ff   <= hostByte;
                  byteReady_ff <= 1'b1;
                  byteIdx_ff   <= byteIdx_ff + 6'h01;
                  if (byteIdx_ff == LAST_UNLOCK)
                     state_ff <= S_SERVICE;
               end
            end

            S_SERVICE: begin
               if (svcEnd)
                  state_ff <= S_IDLE;
            end

            S_READOUT: begin
               if (wordClosed) begin
                  wordCnt_ff <= wordCnt_ff + 8'h01;
                  if (wordCnt_ff == LAST_WORD)
                     state_ff <= S_IDLE;
               end
            end

            S_TRACE: begin
               // The CPU runs one step, then debug mode returns
               if (stepDone) begin
                  debugMode_ff <= 1'b1;
                  stackRpt_ff  <= stackPtr + 16'h0001;
                  state_ff     <= S_IDLE;
               end
            end
            default: state_ff <= S_OFF;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign linkStatus = status_ff;
   assign linkByte   = byteBuf_ff;
   assign inDebug    = debugMode_ff;
   assign vectorReq  = vectorReq_ff;
   assign vectorAddr = vectorAddr_ff;
   assign stepReq    = stepReq_ff;
   assign resumeReq  = resumeReq_ff;
   assign regRdData  = rdData_ff;

endmodule

// file: sim/debug_command_engine_chk.sv
// Port checker for the debug command engine.
// Assumes it is bound onto debug_command_engine with its parameters.
`timescale 1ns/100ps
`include "debug_engine_consts.vh"
module debug_command_engine_chk #(
   parameter MAP_WORDS    = 216,
   parameter PERIPH_WORDS = 180,
   parameter UNLOCK_BYTES = 32
) (
   // Clock and reset
   input wire        sys_clk,
   input wire        srst,
   // Host link
   input wire [7:0]  hostByte,
   input wire        hostByteValid,
   input wire        hostXferEnd,
   input wire [1:0]  linkStatus,
   input wire [7:0]  linkByte,
   // CPU side
   input wire        debugEntry,
   input wire [15:0] stackPtr,
   input wire        stepDone,
   input wire        inDebug,
   input wire        vectorReq,
   input wire [15:0] vectorAddr,
   input wire        stepReq,
   input wire        resumeReq,
   // Register port
   input wire [2:0]  regAddr,
   input wire [31:0] regWrData,
   input wire        regWr,
   input wire        regRd,
   input wire [31:0] regRdData
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   // -----------------------------------------------------------
   // Sequences and properties
   // -----------------------------------------------------------
   sequence s_leftDebug;
      ##[0:1] !inDebug;
   endsequence
   sequence s_resumed;
      s_leftDebug ##[0:2] linkStatus == `ST_NON_DEBUG;
   endsequence
   // Reset is watched while it is asserted, so it is not disabled
   property p_reset;
      disable iff (1'b0) srst |=> linkStatus == `ST_NON_DEBUG && !inDebug
         && regRdData == 32'h0 && !vectorReq;
   endproperty
   property p_vecAddr;
      vectorAddr == `ROM_ENTRY;
   endproperty
   property p_vecCause;
      vectorReq |-> inDebug && $past(hostByteValid);
   endproperty
   property p_vecPulse;
      vectorReq |=> !vectorReq;
   endproperty
   property p_busy;
      vectorReq |=> linkStatus == `ST_BUSY || linkStatus == `ST_VALID;
   endproperty
   property p_validDebug;
      linkStatus == `ST_VALID |-> inDebug;
   endproperty
   property p_step;
      stepReq |-> $past(inDebug) ##0 s_leftDebug;
   endproperty
   property p_resume;
      resumeReq |-> s_resumed;
   endproperty
   property p_rdOnce;
      regRdData != 32'h0 |-> $past(regRd);
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
   a_vecAddr: assert property (p_vecAddr)
      else $error("vector address wrong");
   a_vecCause: assert property (p_vecCause)
      else $error("vector without host byte");
   a_vecPulse: assert property (p_vecPulse)
      else $error("vector request too long");
   a_busy: assert property (p_busy)
      else $error("no busy status after vector");
   a_validDebug: assert property (p_validDebug)
      else $error("valid status outside debug");
   a_step: assert property (p_step)
      else $error("trace step did not leave debug");
   a_resume: assert property (p_resume)
      else $error("return did not reach non-debug");
   a_rdOnce: assert property (p_rdOnce)
      else $error("read data outside its cycle");
endmodule

bind debug_command_engine debug_command_engine_chk #(
   .MAP_WORDS(MAP_WORDS), .PERIPH_WORDS(PERIPH_WORDS),
   .UNLOCK_BYTES(UNLOCK_BYTES)
) chk_u (
   .sys_clk(sys_clk), .srst(srst), .hostByte(hostByte),
   .hostByteValid(hostByteValid), .hostXferEnd(hostXferEnd),
   .linkStatus(linkStatus), .linkByte(linkByte), .debugEntry(debugEntry),
   .stackPtr(stackPtr), .stepDone(stepDone), .inDebug(inDebug),
   .vectorReq(vectorReq), .vectorAddr(vectorAddr), .stepReq(stepReq),
   .resumeReq(resumeReq), .regAddr(regAddr), .regWrData(regWrData),
   .regWr(regWr), .regRd(regRd), .regRdData(regRdData)
);

// file: sim/debug_host_model.sv
// Debug host model: sends command bytes and pulls readout bytes.
// Assumes the device link is synchronous to sys_clk.
`timescale 1ns/100ps
`include "debug_engine_consts.vh"
module debug_host_model (
   // Clock
   input  wire       sys_clk,
   // From the device
   input  wire [1:0] linkStatus,
   input  wire [7:0] linkByte,
   // To the device
   output reg  [7:0] hostByte,
   output reg        hostByteValid,
   output reg        hostXferEnd
);
   integer timeouts;
   initial begin
      hostByte = 8'h00;
      hostByteValid = 1'b0;
      hostXferEnd = 1'b0;
      timeouts = 0;
   end
   task sendByte(input [7:0] b);
      begin
         @(posedge sys_clk);
         hostByte <= b;
         hostByteValid <= 1'b1;
         @(posedge sys_clk);
         hostByteValid <= 1'b0;
         // Released line shows the inverse so a stale byte cannot pass
         hostByte <= ~b;
      end
   endtask
   // Bounded wait; a miss is counted by the bench as a mismatch
   task waitStatus(input [1:0] s);
      integer i;
      begin
         i = 0;
         while (linkStatus !== s && i < 400) begin
            @(posedge sys_clk);
            #1;
            i = i + 1;
         end
         if (i >= 400) timeouts = timeouts + 1;
      end
   endtask
   task readByte(output [7:0] b);
      begin
         repeat (2) @(posedge sys_clk);
         #1;
         waitStatus(`ST_VALID);
         b = linkByte;
         @(posedge sys_clk);
         hostXferEnd <= 1'b1;
         @(posedge sys_clk);
         hostXferEnd <= 1'b0;
      end
   endtask
endmodule

// file: sim/test_debug_command_engine.sv
// Bench for the debug command engine: host model on the link, ROM
// and CPU sides driven here. Assumes full-size counts.
`timescale 1ns/100ps
`include "debug_engine_consts.vh"
module test_debug_command_engine;
   typedef struct {
      logic [7:0] op; int n; logic [7:0] base; logic [3:0] cmd; bit vec;
   } row_t;
   reg         sys_clk, srst, debugEntry, stepDone, regWr, regRd;
   reg  [15:0] stackPtr;
   reg  [2:0]  regAddr;
   reg  [31:0] regWrData, d;
   wire [7:0]  hostByte, linkByte;
   wire        hostByteValid, hostXferEnd, inDebug, vectorReq;
   wire        stepReq, resumeReq;
   wire [1:0]  linkStatus;
   wire [15:0] vectorAddr;
   wire [31:0] regRdData;
   integer     mismatches, n_compared, vecs, steps, resumes, v0, r, i, w;
   reg  [7:0]  got, b;
   reg  [15:0] wd;
   reg         blk, nar;
   row_t       rows [4];

   debug_command_engine #(.MAP_WORDS(216), .PERIPH_WORDS(180),
      .UNLOCK_BYTES(32)) dut_u (
      .sys_clk(sys_clk), .srst(srst), .hostByte(hostByte),
      .hostByteValid(hostByteValid), .hostXferEnd(hostXferEnd),
      .linkStatus(linkStatus), .linkByte(linkByte), .debugEntry(debugEntry),
      .stackPtr(stackPtr), .stepDone(stepDone), .inDebug(inDebug),
      .vectorReq(vectorReq), .vectorAddr(vectorAddr), .stepReq(stepReq),
      .resumeReq(resumeReq), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
   debug_host_model host_u (.sys_clk(sys_clk), .linkStatus(linkStatus),
      .linkByte(linkByte), .hostByte(hostByte),
      .hostByteValid(hostByteValid), .hostXferEnd(hostXferEnd));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      vecs <= vecs + (vectorReq === 1'b1);
      steps <= steps + (stepReq === 1'b1);
      resumes <= resumes + (resumeReq === 1'b1);
   end
   // -----------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------
   task check(input [31:0] sv, input [31:0] ev);
      begin
         n_compared = n_compared + 1;
         if (sv !== ev) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: saw %h wanted %h", $time, sv, ev);
         end
      end
   endtask
   task wrReg(input [2:0] a, input [31:0] v);
      begin
         @(posedge sys_clk);
         regAddr <= a;
         regWrData <= v;
         regWr <= 1'b1;
         @(posedge sys_clk);
         regWr <= 1'b0;
      end
   endtask
   task rdReg(input [2:0] a, output [31:0] v);
      begin
         @(posedge sys_clk);
         regAddr <= a;
         regRd <= 1'b1;
         @(posedge sys_clk);
         regRd <= 1'b0;
         #1 v = regRdData;
      end
   endtask
   task results;
      begin
         mismatches = mismatches + host_u.timeouts;
         $display("compared %0d, mismatches %0d", n_compared, mismatches);
         if (mismatches == 0 && n_compared > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches = mismatches + 1;
      results;
   end
   // -----------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------
   initial begin
      {srst, debugEntry, stepDone, regWr, regRd} = 5'h10;
      {regAddr, regWrData, stackPtr} = {3'h0, 32'h0, 16'h1233};
      {mismatches, n_compared, vecs, steps, resumes} = 0;
      rows[0] = '{`OP_WRITE_MEM, 4, 8'h31, `CMD_WRITE_MEM, 1};
      rows[1] = '{`OP_READ_REG, 2, 8'h52, `CMD_READ_REG, 1};
      rows[2] = '{8'h2f, 0, 8'h00, `CMD_NONE, 0};
      rows[3] = '{`OP_UNLOCK, 32, 8'h80, `CMD_UNLOCK, 1};
      repeat (6) @(posedge sys_clk);
      srst <= 1'b0;
      rdReg(3'h7, d);
      check(d, 32'h0);
      rdReg(`REG_CONTROL, d);
      check(d[5], `PW_LOCK_RESET);
      check(linkStatus, `ST_NON_DEBUG);
      @(posedge sys_clk) debugEntry <= 1'b1;
      @(posedge sys_clk) debugEntry <= 1'b0;
      stackPtr <= 16'h4321;
      host_u.waitStatus(`ST_IDLE);
      rdReg(`REG_STACK_RPT, d);
      check(d[15:0], 16'h1234);
      for (r = 0; r < 4; r = r + 1) begin
         v0 = vecs;
         host_u.sendByte(rows[r].op);
         for (i = 0; i < rows[r].n; i = i + 1) begin
            b = rows[r].base + i[7:0];
            host_u.sendByte(b);
         end
         repeat (3) @(posedge sys_clk);
         #1 check(vecs - v0, rows[r].vec);
         if (rows[r].vec) begin
            check(linkStatus, `ST_BUSY);
            rdReg(`REG_CONTROL, d);
            check(d[3:0], rows[r].cmd);
            check(d[6], rows[r].n == 32);
            rdReg(`REG_ADDR_HOLD, d);
            if (rows[r].n < 5)
               check(d[15:0], {rows[r].base + 8'h01, rows[r].base});
            rdReg(`REG_DATA_HOLD, d);
            if (rows[r].n == 4)
               check(d[15:0], {rows[r].base + 8'h03, rows[r].base + 8'h02});
            rdReg(`REG_BYTE_BUF, d);
            check(d[7:0], rows[r].n == 32 ? b : 8'h00);
            // Ending with bit 5 low clears the lock, as after a match
            wrReg(`REG_CONTROL, rows[r].op == `OP_UNLOCK ? 32'h80 : 32'ha0);
            host_u.waitStatus(`ST_IDLE);
         end else
            check(linkStatus, `ST_IDLE);
      end
      rdReg(`REG_CONTROL, d);
      check(d[5], 1'b0);
      host_u.sendByte(`OP_READ_MAP);
      host_u.readByte(got);
      check(got, `MAP_HEADER_BYTE);
      rdReg(`REG_CONTROL, d);
      check(d[3:0], `CMD_READ_MAP);
      for (w = 0; w < 216; w = w + 1) begin
         nar = (w % 3 == 0);
         blk = (w == 7 || w == 190);
         wd = {~w[7:0], w[7:0]};
         wrReg(`REG_WORD_OUT, {14'h0, blk, nar, wd});
         host_u.readByte(got);
         check(got, blk ? 8'h00 : wd[7:0]);
         if (!(nar && w >= 180)) begin
            host_u.readByte(got);
            check(got, blk ? 8'h00 : wd[15:8]);
         end
      end
      host_u.waitStatus(`ST_IDLE);
      check(linkStatus, `ST_IDLE);
      v0 = steps;
      host_u.sendByte(`OP_TRACE);
      repeat (2) @(posedge sys_clk);
      #1 check(steps - v0, 1);
      check(inDebug, 1'b0);
      check(linkStatus, `ST_BUSY);
      @(posedge sys_clk) stackPtr <= 16'h2000;
      stepDone <= 1'b1;
      @(posedge sys_clk) stepDone <= 1'b0;
      host_u.waitStatus(`ST_IDLE);
      check(inDebug, 1'b1);
      rdReg(`REG_STACK_RPT, d);
      check(d[15:0], 16'h2001);
      v0 = resumes;
      host_u.sendByte(`OP_RETURN);
      repeat (3) @(posedge sys_clk);
      #1 check(resumes - v0, 1);
      check(linkStatus, `ST_NON_DEBUG);
      v0 = vecs;
      host_u.sendByte(`OP_READ_REG);
      host_u.sendByte(8'h01);
      host_u.sendByte(8'h00);
      repeat (3) @(posedge sys_clk);
      #1 check(vecs - v0, 0);
      results;
   end
endmodule
